// file: bench/tb_clear_complement_decrement_ops.sv
`timescale 1ns/100ps
`include "ccdo_cfg.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] %0t got %h want %h", $time, (a), (b)); end end

module tb_clear_complement_decrement_ops;
  import ccdo_pkg::*;
  logic        clk;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        expiry_n;
  logic        sleep_n;
  logic        zero;
  int          fails;
  int          check_count;
  logic [31:0] rd;
  logic        err;
  logic [6:0]  f;
  logic [7:0]  v;
  logic [7:0]  a;
  logic [7:0]  r;
  logic        d;
  logic        inv;
  logic [7:0]  cv [4] = '{8'h01, 8'hFF, 8'h00, 8'h00};

  ccdo_core dut (
    .CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .EXPIRY_FLAG_N(expiry_n),
    .SLEEP_FLAG_N(sleep_n), .ZERO_FLAG(zero)
  ); // ccdo_core

  task automatic end_of_test();
    if (fails == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // leading edge wait keeps back-to-back calls from double assigning psel
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] wd);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // no wait count assumed; the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    apb(1'b1, ad, wd);
  endtask

  task automatic rdchk(input logic [7:0] ad, input logic [31:0] ex);
    apb(1'b0, ad, 32'h0);
    `CHK(rd, ex)
  endtask

  task automatic op(input logic [13:0] w);
    wr(`CCDO_OFF_INSTR, {18'h0, w});
  endtask

  function automatic logic [7:0] res(input logic i, input logic [7:0] x);
    return i ? ~x : x - 8'h01;
  endfunction

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // whole run is about 1200 cycles
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    end_of_test();
  end

  initial begin
    reset   = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    rd = $urandom(88);
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rdchk(`CCDO_OFF_STATUS, 32'h18);
    rdchk(`CCDO_OFF_ACC, 32'h0);
    // corners first: results of zero and wrap to FF
    for (int i = 0; i < 20; i++) begin
      f   = 7'($urandom);
      a   = 8'($urandom);
      v   = (i < 4) ? cv[i] : 8'($urandom);
      inv = (i < 4) ? i[0] : 1'($urandom);
      d   = (i < 4) ? i[1] : 1'($urandom);
      r   = res(inv, v);
      wr(`CCDO_OFF_FADDR, {25'h0, f});
      wr(`CCDO_OFF_FDATA, {24'h0, v});
      wr(`CCDO_OFF_ACC, {24'h0, a});
      op((inv ? `CCDO_OPC_INV : `CCDO_OPC_DEC) | {6'h00, d, f});
      rdchk(`CCDO_OFF_ACC, {24'h0, d ? a : r});
      rdchk(`CCDO_OFF_FDATA, {24'h0, d ? r : v});
      `CHK(zero, (r == 8'h00))
    end
    // consecutive words each execute fully
    v = 8'($urandom);
    wr(`CCDO_OFF_FDATA, {24'h0, v});
    op(`CCDO_OPC_DEC | {6'h01, f});
    op(`CCDO_OPC_DEC | {6'h01, f});
    op(`CCDO_OPC_INV | {6'h00, f});
    rdchk(`CCDO_OFF_FDATA, {24'h0, v - 8'h02});
    rdchk(`CCDO_OFF_ACC, {24'h0, ~(v - 8'h02)});
    v = 8'($urandom) | 8'h01;
    a = 8'($urandom) | 8'h01;
    wr(`CCDO_OFF_FDATA, {24'h0, v});
    wr(`CCDO_OFF_ACC, {24'h0, a});
    wr(`CCDO_OFF_STATUS, 32'h18);
    op(`CCDO_OPC_ZREG | {7'h00, f});
    rdchk(`CCDO_OFF_FDATA, 32'h0);
    `CHK(zero, 1'b1)
    rdchk(`CCDO_OFF_ACC, {24'h0, a});
    wr(`CCDO_OFF_FDATA, {24'h0, v});
    wr(`CCDO_OFF_STATUS, 32'h18);
    op(`CCDO_OPC_ZACC);
    rdchk(`CCDO_OFF_ACC, 32'h0);
    `CHK(zero, 1'b1)
    rdchk(`CCDO_OFF_FDATA, {24'h0, v});
    // an unknown word is kept but changes nothing
    op(14'h3FFF);
    rdchk(`CCDO_OFF_INSTR, 32'h3FFF);
    rdchk(`CCDO_OFF_ACC, 32'h0);
    // let the counter move off zero so the restart is visible
    repeat (600) @(posedge clk);
    wr(`CCDO_OFF_STATUS, 32'h0);
    apb(1'b0, `CCDO_OFF_WDOGCNT, 32'h0);
    `CHK({expiry_n, sleep_n, rd != 32'h0}, 3'b001)
    op(`CCDO_OPC_WDR);
    apb(1'b0, `CCDO_OFF_WDOGPRE, 32'h0);
    `CHK(rd < 32'h10, 1'b1)
    rdchk(`CCDO_OFF_WDOGCNT, 32'h0);
    `CHK({expiry_n, sleep_n}, 2'b11)
    apb(1'b0, 8'h1C, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    end_of_test();
  end
endmodule // tb_clear_complement_decrement_ops

// file: verilog/ccdo_alu.sv
`timescale 1ns/100ps
`include "ccdo_cfg.svh"

module ccdo_alu (
  // operation in
  input  wire ccdo_pkg::ccdo_alu_in_t  alu_in,
  // result out
  output ccdo_pkg::ccdo_alu_out_t       alu_out
);
  import ccdo_pkg::*;

  always_comb begin
    alu_out.result = alu_in.operand;
    unique case (alu_in.op)
      CCDO_OP_ZREG, CCDO_OP_ZACC: alu_out.result = 8'h00;
      CCDO_OP_INV:  alu_out.result = ~alu_in.operand;
      CCDO_OP_DEC:  alu_out.result = alu_in.operand - 8'h01;
      CCDO_OP_NONE, CCDO_OP_WDR: alu_out.result = alu_in.operand;
    endcase
    alu_out.zero = (alu_out.result == 8'h00);
  end

endmodule // ccdo_alu

// file: verilog/ccdo_cfg.svh
`ifndef CCDO_CFG_SVH
`define CCDO_CFG_SVH

// apb byte offsets
`define CCDO_OFF_INSTR   8'h00
`define CCDO_OFF_ACC     8'h04
`define CCDO_OFF_STATUS  8'h08
`define CCDO_OFF_WDOGCNT 8'h0C
`define CCDO_OFF_WDOGPRE 8'h10
`define CCDO_OFF_FADDR   8'h14
`define CCDO_OFF_FDATA   8'h18

// status register bit positions
`define CCDO_ST_ZERO     2
`define CCDO_ST_SLEEP_N  3
`define CCDO_ST_EXPIRY_N 4

// reset values
`define CCDO_RST_ACC     8'h00
`define CCDO_RST_FLAG_N  1'b1
`define CCDO_RST_WDOG    8'h00
`define CCDO_RST_DATA    8'h00

// program word fields and opcode patterns
`define CCDO_OPC_MSB     11
`define CCDO_OPC_LSB     8
`define CCDO_DEST_BIT    7
`define CCDO_FILE_MSB    6
`define CCDO_OPC_ZREG    14'h0180
`define CCDO_MSK_ZREG    14'h3F80
`define CCDO_OPC_ZACC    14'h0103
`define CCDO_OPC_INV     14'h0900
`define CCDO_OPC_DEC     14'h0300
`define CCDO_MSK_FD      14'h3F00
`define CCDO_OPC_WDR     14'h0064

// watchdog counts
`define CCDO_PRE_MAX     8'hFF
`define CCDO_WDOG_MAX    8'hFF

`endif

// file: verilog/ccdo_core.sv
`timescale 1ns/100ps
`include "ccdo_cfg.svh"

module ccdo_core (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // status levels
  output logic             EXPIRY_FLAG_N,
  output logic             SLEEP_FLAG_N,
  output logic             ZERO_FLAG
);
  import ccdo_pkg::*;

  ccdo_state_t   st_ff;
  ccdo_state_t   nxt_st;
  ccdo_alu_in_t  alu_in;
  ccdo_alu_out_t alu_out;
  logic          exec;
  logic          wr_take;
  logic          rd_phase;
  ccdo_op_t      exec_op;
  logic [6:0]    exec_f;
  logic          exec_d;
  logic [7:0]    operand;
  logic          wdog_wrap;

  function automatic ccdo_op_t decode_op(input logic [13:0] w);
    if ((w & `CCDO_MSK_ZREG) == `CCDO_OPC_ZREG)
      return CCDO_OP_ZREG;
    else if (w == `CCDO_OPC_ZACC)
      return CCDO_OP_ZACC;
    else if ((w & `CCDO_MSK_FD) == `CCDO_OPC_INV)
      return CCDO_OP_INV;
    else if ((w & `CCDO_MSK_FD) == `CCDO_OPC_DEC)
      return CCDO_OP_DEC;
    else if (w == `CCDO_OPC_WDR)
      return CCDO_OP_WDR;
    else
      return CCDO_OP_NONE;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return (a == `CCDO_OFF_INSTR)  || (a == `CCDO_OFF_ACC)    ||
           (a == `CCDO_OFF_STATUS) || (a == `CCDO_OFF_WDOGCNT) ||
           (a == `CCDO_OFF_WDOGPRE) || (a == `CCDO_OFF_FADDR)  ||
           (a == `CCDO_OFF_FDATA);
  endfunction

  function automatic logic [7:0] status_byte(input ccdo_state_t s);
    logic [7:0] b;
    b = 8'h00;
    b[`CCDO_ST_ZERO]     = s.zero;
    b[`CCDO_ST_SLEEP_N]  = s.sleep_n;
    b[`CCDO_ST_EXPIRY_N] = s.expiry_n;
    return b;
  endfunction

  // one wait state: read data is registered at the same edge that raises pready
  assign rd_phase = PSEL && PENABLE && !st_ff.pready;
  assign wr_take  = PSEL && PENABLE && st_ff.pready && PWRITE &&
                    !st_ff.pslverr;
  assign exec     = wr_take && (PADDR == `CCDO_OFF_INSTR);
  assign exec_op  = exec ? decode_op(PWDATA[13:0]) : CCDO_OP_NONE;
  assign exec_f   = PWDATA[`CCDO_FILE_MSB:0];
  assign exec_d   = PWDATA[`CCDO_DEST_BIT];
  assign operand  = st_ff.mem[exec_f];
  assign wdog_wrap = (st_ff.wdog_pre == `CCDO_PRE_MAX) &&
                     (st_ff.wdog_cnt == `CCDO_WDOG_MAX);

  assign alu_in.op      = exec_op;
  assign alu_in.operand = operand;

  ccdo_alu u_alu (
    .alu_in  (alu_in),
    .alu_out (alu_out)
  );

  always_comb begin
    nxt_st = st_ff;
    nxt_st.pready  = rd_phase;
    nxt_st.pslverr = rd_phase && !is_mapped(PADDR);
    if (rd_phase) begin
      nxt_st.prdata = 32'h0000_0000;
      unique case (PADDR)
        `CCDO_OFF_INSTR:  nxt_st.prdata[13:0] = st_ff.instr;
        `CCDO_OFF_ACC:    nxt_st.prdata[7:0]  = st_ff.acc;
        `CCDO_OFF_STATUS: nxt_st.prdata[7:0]  = status_byte(st_ff);
        `CCDO_OFF_WDOGCNT: nxt_st.prdata[7:0] = st_ff.wdog_cnt;
        `CCDO_OFF_WDOGPRE: nxt_st.prdata[7:0] = st_ff.wdog_pre;
        `CCDO_OFF_FADDR:  nxt_st.prdata[6:0]  = st_ff.faddr;
        `CCDO_OFF_FDATA:  nxt_st.prdata[7:0]  = st_ff.mem[st_ff.faddr];
        default:          nxt_st.prdata       = 32'h0000_0000;
      endcase
    end
    // free-running watchdog, prescaler first
    nxt_st.wdog_pre = st_ff.wdog_pre + 8'h01;
    if (st_ff.wdog_pre == `CCDO_PRE_MAX)
      nxt_st.wdog_cnt = st_ff.wdog_cnt + 8'h01;
    // software register writes
    if (wr_take) begin
      unique case (PADDR)
        `CCDO_OFF_INSTR:  nxt_st.instr = PWDATA[13:0];
        `CCDO_OFF_ACC:    nxt_st.acc   = PWDATA[7:0];
        `CCDO_OFF_STATUS: begin
          nxt_st.zero     = PWDATA[`CCDO_ST_ZERO];
          nxt_st.sleep_n  = PWDATA[`CCDO_ST_SLEEP_N];
          nxt_st.expiry_n = PWDATA[`CCDO_ST_EXPIRY_N];
        end
        `CCDO_OFF_FADDR:  nxt_st.faddr = PWDATA[6:0];
        `CCDO_OFF_FDATA:  nxt_st.mem[st_ff.faddr] = PWDATA[7:0];
        default: ;
      endcase
    end
    // executes at the accepting edge; no pipeline slot is lost
    unique case (exec_op)
      CCDO_OP_ZREG: begin
        nxt_st.mem[exec_f] = alu_out.result;
        nxt_st.zero        = 1'b1;
      end
      CCDO_OP_ZACC: begin
        nxt_st.acc  = alu_out.result;
        nxt_st.zero = 1'b1;
      end
      CCDO_OP_INV, CCDO_OP_DEC: begin
        if (exec_d)
          nxt_st.mem[exec_f] = alu_out.result;
        else
          nxt_st.acc = alu_out.result;
        nxt_st.zero = alu_out.zero;
      end
      CCDO_OP_WDR: begin
        nxt_st.wdog_cnt = 8'h00;
        nxt_st.wdog_pre = 8'h00;
        nxt_st.expiry_n = 1'b1;
        nxt_st.sleep_n  = 1'b1;
      end
      CCDO_OP_NONE: ;
    endcase
    // expiry event beats a status write in the same cycle, but not a WDR program word
    if (wdog_wrap && exec_op != CCDO_OP_WDR)
      nxt_st.expiry_n = 1'b0;
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      st_ff          <= '0;
      st_ff.acc      <= `CCDO_RST_ACC;
      st_ff.sleep_n  <= `CCDO_RST_FLAG_N;
      st_ff.expiry_n <= `CCDO_RST_FLAG_N;
      st_ff.wdog_cnt <= `CCDO_RST_WDOG;
      st_ff.wdog_pre <= `CCDO_RST_WDOG;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign PRDATA        = st_ff.prdata;
  assign PREADY        = st_ff.pready;
  assign PSLVERR       = st_ff.pslverr;
  assign EXPIRY_FLAG_N = st_ff.expiry_n;
  assign SLEEP_FLAG_N  = st_ff.sleep_n;
  assign ZERO_FLAG     = st_ff.zero;

  a_zreg_clears: assert property (
    @(posedge CLK) disable iff (RESET)
    (exec_op == CCDO_OP_ZREG) |=>
      (st_ff.mem[$past(exec_f)] == 8'h00) && st_ff.zero)
    else $error("zero-register op did not clear register and set zero");

  a_inv_result: assert property (
    @(posedge CLK) disable iff (RESET)
    (exec_op == CCDO_OP_INV && !exec_d) |=>
      (st_ff.acc == ~$past(operand)) &&
      (st_ff.zero == ($past(operand) == 8'hFF)))
    else $error("invert op gave wrong result");

  a_dec_zero: assert property (
    @(posedge CLK) disable iff (RESET)
    (exec_op == CCDO_OP_DEC && operand == 8'h01) |=>
      st_ff.zero &&
      (($past(exec_d) ? st_ff.mem[$past(exec_f)] : st_ff.acc) == 8'h00))
    else $error("decrement to zero did not set zero flag");

  a_dest_acc: assert property (
    @(posedge CLK) disable iff (RESET)
    ((exec_op == CCDO_OP_INV || exec_op == CCDO_OP_DEC) && !exec_d) |=>
      (st_ff.mem[$past(exec_f)] == $past(operand)) &&
      (st_ff.acc == (($past(exec_op) == CCDO_OP_INV) ?
                     ~$past(operand) : $past(operand) - 8'h01)))
    else $error("destination 0 changed file or missed accumulator");

  a_dest_file: assert property (
    @(posedge CLK) disable iff (RESET)
    ((exec_op == CCDO_OP_INV || exec_op == CCDO_OP_DEC) && exec_d) |=>
      (st_ff.mem[$past(exec_f)] == (($past(exec_op) == CCDO_OP_INV) ?
                     ~$past(operand) : $past(operand) - 8'h01)) &&
      $stable(st_ff.acc))
    else $error("destination 1 result not written back");

  a_wdog_cnt_clear: assert property (
    @(posedge CLK) disable iff (RESET)
    (exec_op == CCDO_OP_WDR) |=> (st_ff.wdog_cnt == 8'h00))
    else $error("watchdog counter not cleared");

  a_wdog_pre_clear: assert property (
    @(posedge CLK) disable iff (RESET)
    (exec_op == CCDO_OP_WDR) |=>
      (st_ff.wdog_pre == 8'h00) ##1 (st_ff.wdog_pre == 8'h01))
    else $error("watchdog prescaler not cleared");

  a_flags_set: assert property (
    @(posedge CLK) disable iff (RESET)
    (exec_op == CCDO_OP_WDR) |=> (EXPIRY_FLAG_N && SLEEP_FLAG_N))
    else $error("restart did not set both status flags");

  a_zacc_only: assert property (
    @(posedge CLK) disable iff (RESET)
    (exec_op == CCDO_OP_ZACC) |=>
      (st_ff.acc == 8'h00) && st_ff.zero && $stable(st_ff.mem))
    else $error("zero-accumulator op wrong");

  a_one_cycle: assert property (
    @(posedge CLK) disable iff (RESET)
    (PSEL && PENABLE && !PREADY) |=> PREADY ##1 !PREADY)
    else $error("access did not finish in one wait state");

  a_zreg_acc_kept: assert property (
    @(posedge CLK) disable iff (RESET)
    (exec_op == CCDO_OP_ZREG) |=> $stable(st_ff.acc))
    else $error("zero-register op disturbed the accumulator");

  a_inv_file: assert property (
    @(posedge CLK) disable iff (RESET)
    (exec_op == CCDO_OP_INV && exec_d) |=>
      (st_ff.mem[$past(exec_f)] == ~$past(operand)) &&
      (st_ff.zero == ($past(operand) == 8'hFF)))
    else $error("invert op wrote wrong file value");

  a_dec_result: assert property (
    @(posedge CLK) disable iff (RESET)
    (exec_op == CCDO_OP_DEC && !exec_d) |=>
      (st_ff.acc == $past(operand) - 8'h01) &&
      (st_ff.zero == ($past(operand) == 8'h01)))
    else $error("decrement op gave wrong result");

  a_wdr_quiet: assert property (
    @(posedge CLK) disable iff (RESET)
    (exec_op == CCDO_OP_WDR) |=>
      $stable(st_ff.acc) && $stable(st_ff.mem) && $stable(st_ff.zero))
    else $error("restart touched data state");

  a_next_word: assert property (
    @(posedge CLK) disable iff (RESET)
    exec |=> (st_ff.instr == $past(PWDATA[13:0])))
    else $error("accepted program word was dropped");

  a_none_quiet: assert property (
    @(posedge CLK) disable iff (RESET)
    (exec && exec_op == CCDO_OP_NONE) |=>
      $stable(st_ff.acc) && $stable(st_ff.mem) && $stable(st_ff.zero))
    else $error("unknown word changed state");

  a_acc_hold: assert property (
    @(posedge CLK) disable iff (RESET)
    !wr_take |=> $stable(st_ff.acc))
    else $error("accumulator changed without a write");

  a_sleep_hold: assert property (
    @(posedge CLK) disable iff (RESET)
    !wr_take |=> $stable(SLEEP_FLAG_N))
    else $error("sleep flag changed without a write");

  a_ready_pulse: assert property (
    @(posedge CLK) disable iff (RESET)
    PREADY |=> !PREADY)
    else $error("ready held longer than one cycle");

  a_err_with_ready: assert property (
    @(posedge CLK) disable iff (RESET)
    PSLVERR |-> PREADY && (PRDATA == 32'h0000_0000))
    else $error("error response without ready or with data");

endmodule // ccdo_core

// file: verilog/ccdo_pkg.sv
package ccdo_pkg;

  typedef enum logic [5:0] {
    CCDO_OP_NONE = 6'h01,
    CCDO_OP_ZREG = 6'h02,
    CCDO_OP_ZACC = 6'h04,
    CCDO_OP_INV  = 6'h08,
    CCDO_OP_DEC  = 6'h10,
    CCDO_OP_WDR  = 6'h20
  } ccdo_op_t;

  typedef struct packed {
    ccdo_op_t   op;
    logic [7:0] operand;
  } ccdo_alu_in_t;

  typedef struct packed {
    logic [7:0] result;
    logic       zero;
  } ccdo_alu_out_t;

  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
    logic [13:0]       instr;
    logic [7:0]        acc;
    logic              zero;
    logic              sleep_n;
    logic              expiry_n;
    logic [7:0]        wdog_cnt;
    logic [7:0]        wdog_pre;
    logic [6:0]        faddr;
    logic [127:0][7:0] mem;
  } ccdo_state_t;

endpackage
